// ===== verilog/timer_pair_regs.svh
`ifndef TIMER_PAIR_REGS_SVH
`define TIMER_PAIR_REGS_SVH
// Register indexes; byte address is four times the index
`define TP_IDX_LCNT 10'h106
`define TP_IDX_HOLD 10'h108
`define TP_IDX_HCNT 10'h10a
`define TP_IDX_PERL 10'h10c
`define TP_IDX_PERH 10'h10e
`define TP_IDX_CTLL 10'h110
`define TP_IDX_CTLH 10'h112
`define TP_IDX_STAT 10'h114
// Control fields
`define TP_ON 15
`define TP_IDLE_STOP 13
`define TP_GATE 6
`define TP_PS_HI 5
`define TP_PS_LO 4
`define TP_COMBINED 3
`define TP_CSRC 1
`define TP_CTLL_MASK 16'ha07a
`define TP_CTLH_MASK 16'ha072
// Status fields
`define TP_FLAG_L 0
`define TP_FLAG_H 1
`define TP_IE_L 8
`define TP_IE_H 9
// Reset values
`define TP_CNT_RST 16'h0000
`define TP_PER_RST 16'hffff
`define TP_CTL_RST 16'h0000
// Prescaler terminal counts
`define TP_DIV1_LAST 8'h00
`define TP_DIV8_LAST 8'h07
`define TP_DIV64_LAST 8'h3f
`define TP_DIV256_LAST 8'hff
`endif

// ===== verilog/timer_pair_pkg.sv
package timer_pair_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {DIV_1, DIV_8, DIV_64, DIV_256} prescale_e;
endpackage

// ===== verilog/timer_pair.sv
`timescale 1ns/1ps
`include "timer_pair_regs.svh"
// Contract
// [RULE1] Cascaded: low timer is low word, high timer is high word.
// [RULE2] Cascaded: high control register ignored; low control rules everything. Code: turning the high timer off still clears both prescalers.
// [RULE3] Cascaded: low clock and gate used; high flag and enable signal it.
// [RULE4] Uncascaded: each timer does timer or synchronous counter mode, never asynchronous.
// [RULE5] Low prescaler output is resynchronised; high prescaler output is not.
// [RULE6] 32-bit timer counts each cycle to combined period, then wraps to zero.
// [RULE7] Reading low count captures high count into the holding register.
// [RULE8] Holding written first; next low count write loads it into high count.
// [RULE9] 32-bit counter counts synchronised external rising edges, wraps at period.
// [RULE10] Idle stops counting when stop-in-idle is set; resumes after Idle.
// [RULE11] Gate mode with internal clock counts cycles while the pin is high.
// [RULE12] Gated cascade uses low timer clock; high gate setting ignored.
// [RULE13] Gate falling edge stops accumulation without clearing the count.
// [RULE14] Combined period match emits a converter trigger pulse.
// [RULE15] Prescaler divides by 1, 8, 64 or 256, from control bits 5:4.
// [RULE16] Cascaded: only the low timer prescaler is used.
// [RULE17] Prescaler cleared by count write, timer-on clear, or reset.
// [RULE18] Disabled timer: count writes leave the prescaler untouched.
// [RULE19] Control writes never change the counts.
// [RULE20] Match or gate fall sets high flag; only software clears it.
// [RULE21] Sleep stops all counting.
// [RULE22] Prescale code 00=1, 01=8, 10=64, 11=256.
// [RULE23] Combined-mode bit in low control selects two 16-bit or one 32-bit.
module timer_pair (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_clock_gate_pin,
   input wire logic high_half_ext_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   output logic low_irq_req,
   output logic high_irq_req,
   output logic adc_trigger
);

   timer_pair_pkg::word_t low_half_count, high_half_count, high_half_holding;
   timer_pair_pkg::word_t next_low, next_high;
   timer_pair_pkg::word_t period_low_half, period_high_half;
   timer_pair_pkg::word_t low_half_control, high_half_control;
   logic low_match_flag, period_match_flag;
   logic low_irq_enable, period_match_irq_enable;
   logic [1:0] pin_meta, pin_sync, pin_prev;
   logic [9:0] idx;
   logic setup, acc, wr;
   logic wr_lcnt, wr_hcnt, wr_hold, wr_perl, wr_perh, wr_ctll, wr_ctlh, wr_stat;
   logic cnt_wr, on_fall, combined;
   timer_pair_pkg::word_t ctl [2];
   logic [1:0] t_on, t_run, t_gated, t_src, ps_hit, ps_clr, tick, gate_fall;
   logic [7:0] ps [2];
   logic tick_low_q;
   logic [31:0] cat_cnt, cat_per, inc32;
   logic m32, m_l, m_h, set_l, set_h, clr_l, clr_h;
   logic rd_hit;
   timer_pair_pkg::word_t rd_data;

   function automatic logic [7:0] ps_last(input timer_pair_pkg::word_t c);
      timer_pair_pkg::prescale_e sel;
      sel = timer_pair_pkg::prescale_e'(c[`TP_PS_HI:`TP_PS_LO]);
      unique case (sel)
         timer_pair_pkg::DIV_1: ps_last = `TP_DIV1_LAST; // RULE22
         timer_pair_pkg::DIV_8: ps_last = `TP_DIV8_LAST;
         timer_pair_pkg::DIV_64: ps_last = `TP_DIV64_LAST;
         timer_pair_pkg::DIV_256: ps_last = `TP_DIV256_LAST;
      endcase
   endfunction

   function automatic timer_pair_pkg::word_t step16(
      input timer_pair_pkg::word_t c,
      input timer_pair_pkg::word_t p
   );
      step16 = (c == p) ? `TP_CNT_RST : c + 16'h0001;
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         pin_prev <= 2'h0;
      end else begin
         pin_meta <= {high_half_ext_pin, external_clock_gate_pin};
         pin_sync <= pin_meta; // RULE4
         pin_prev <= pin_sync;
      end
   end

   // ****************************************
   // Bus decode
   // ****************************************
   assign idx = paddr[11:2];
   assign setup = psel & ~penable & ~pready;
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign wr_lcnt = wr & (idx == `TP_IDX_LCNT);
   assign wr_hcnt = wr & (idx == `TP_IDX_HCNT);
   assign wr_hold = wr & (idx == `TP_IDX_HOLD);
   assign wr_perl = wr & (idx == `TP_IDX_PERL);
   assign wr_perh = wr & (idx == `TP_IDX_PERH);
   assign wr_ctll = wr & (idx == `TP_IDX_CTLL);
   assign wr_ctlh = wr & (idx == `TP_IDX_CTLH);
   assign wr_stat = wr & (idx == `TP_IDX_STAT);
   assign cnt_wr = wr_lcnt | wr_hcnt;

   // Turning either timer off clears the prescalers
   assign on_fall = (wr_ctll & low_half_control[`TP_ON] & ~pwdata[`TP_ON])
      | (wr_ctlh & high_half_control[`TP_ON] & ~pwdata[`TP_ON]); // RULE17

   assign combined = low_half_control[`TP_COMBINED]; // RULE23
   assign ctl[0] = low_half_control;
   assign ctl[1] = high_half_control;

   // ****************************************
   // Clock source and prescalers
   // ****************************************
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         t_on[i] = ctl[i][`TP_ON];
         // Sleep stops the core clock, Idle only when asked to
         t_run[i] = t_on[i] & ~cpu_sleep
            & ~(cpu_idle & ctl[i][`TP_IDLE_STOP]); // RULE10 RULE21
         t_gated[i] = t_on[i] & ~ctl[i][`TP_CSRC] & ctl[i][`TP_GATE];
         if (ctl[i][`TP_CSRC]) begin
            t_src[i] = pin_sync[i] & ~pin_prev[i]; // RULE9
         end else if (ctl[i][`TP_GATE]) begin
            t_src[i] = pin_sync[i]; // RULE11
         end else begin
            t_src[i] = 1'b1;
         end
         ps_hit[i] = t_run[i] & t_src[i] & (ps[i] == ps_last(ctl[i])); // RULE15
         // A write while off cannot clear: the prescaler is not clocked
         ps_clr[i] = (cnt_wr & t_on[i]) | on_fall; // RULE17 RULE18
         gate_fall[i] = t_gated[i] & pin_prev[i] & ~pin_sync[i]; // RULE13
      end
      // Low path pays one cycle for its resynchronising stage
      tick[0] = tick_low_q & t_run[0]; // RULE5
      tick[1] = ps_hit[1] & ~ps_clr[1] & ~combined; // RULE16
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            ps[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ps_clr[i]) begin
               ps[i] <= 8'h00; // RULE17
            end else if (t_run[i] & t_src[i]) begin
               ps[i] <= ps_hit[i] ? 8'h00 : ps[i] + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_low_q <= 1'b0;
      end else begin
         tick_low_q <= ps_hit[0] & ~ps_clr[0]; // RULE5
      end
   end

   // ****************************************
   // Counters
   // ****************************************
   assign cat_cnt = {high_half_count, low_half_count}; // RULE1
   assign cat_per = {period_high_half, period_low_half};
   assign inc32 = cat_cnt + 32'h0000_0001;
   assign m32 = combined & tick[0] & (cat_cnt == cat_per) & ~cnt_wr; // RULE14
   assign m_l = ~combined & tick[0] & (low_half_count == period_low_half) & ~wr_lcnt;
   assign m_h = ~combined & tick[1] & (high_half_count == period_high_half) & ~wr_hcnt;

   always_comb begin
      next_low = low_half_count;
      next_high = high_half_count;
      if (combined & tick[0]) begin
         {next_high, next_low} = (cat_cnt == cat_per) ? 32'h0000_0000 : inc32; // RULE6
      end
      if (~combined & tick[0]) begin
         next_low = step16(low_half_count, period_low_half); // RULE4
      end
      if (tick[1]) begin
         next_high = step16(high_half_count, period_high_half);
      end
      // Direct writes win over a tick in the same cycle
      if (wr_lcnt) begin
         next_low = pwdata[15:0];
         if (combined) begin
            next_high = high_half_holding; // RULE8
         end
      end
      if (wr_hcnt) begin
         next_high = pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_half_count <= `TP_CNT_RST;
         high_half_count <= `TP_CNT_RST;
      end else begin
         low_half_count <= next_low;
         high_half_count <= next_high;
      end
   end

   // Capture at setup so the read word and the held word match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_half_holding <= `TP_CNT_RST;
      end else if (setup & ~pwrite & (idx == `TP_IDX_LCNT)) begin
         high_half_holding <= high_half_count; // RULE7
      end else if (wr_hold) begin
         high_half_holding <= pwdata[15:0]; // RULE8
      end
   end

   // ****************************************
   // Period and control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_low_half <= `TP_PER_RST;
         period_high_half <= `TP_PER_RST;
      end else begin
         if (wr_perl) begin
            period_low_half <= pwdata[15:0];
         end
         if (wr_perh) begin
            period_high_half <= pwdata[15:0];
         end
      end
   end

   // Control writes touch no count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_half_control <= `TP_CTL_RST;
         high_half_control <= `TP_CTL_RST;
      end else begin
         if (wr_ctll) begin
            low_half_control <= pwdata[15:0] & `TP_CTLL_MASK; // RULE19
         end
         if (wr_ctlh) begin
            high_half_control <= pwdata[15:0] & `TP_CTLH_MASK;
         end
      end
   end

   // ****************************************
   // Flags and requests
   // ****************************************
   // High timer gate settings are dead weight while cascaded
   assign set_h = m32 | m_h | (combined & gate_fall[0])
      | (~combined & gate_fall[1]); // RULE2 RULE3 RULE12 RULE20
   assign set_l = m_l | (~combined & gate_fall[0]);
   assign clr_l = wr_stat & pwdata[`TP_FLAG_L];
   assign clr_h = wr_stat & pwdata[`TP_FLAG_H];

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_match_flag <= 1'b0;
         period_match_flag <= 1'b0;
      end else begin
         low_match_flag <= set_l | (low_match_flag & ~clr_l);
         period_match_flag <= set_h | (period_match_flag & ~clr_h); // RULE20
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_irq_enable <= 1'b0;
         period_match_irq_enable <= 1'b0;
      end else if (wr_stat) begin
         low_irq_enable <= pwdata[`TP_IE_L];
         period_match_irq_enable <= pwdata[`TP_IE_H];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_irq_req <= 1'b0;
         high_irq_req <= 1'b0;
         adc_trigger <= 1'b0;
      end else begin
         low_irq_req <= low_match_flag & low_irq_enable;
         high_irq_req <= period_match_flag & period_match_irq_enable; // RULE3
         adc_trigger <= m32 | m_h; // RULE14
      end
   end

   // ****************************************
   // Read back
   // ****************************************
   always_comb begin
      rd_hit = 1'b1;
      rd_data = 16'h0000;
      case (idx)
         `TP_IDX_LCNT: rd_data = low_half_count;
         `TP_IDX_HOLD: rd_data = high_half_holding;
         `TP_IDX_HCNT: rd_data = high_half_count;
         `TP_IDX_PERL: rd_data = period_low_half;
         `TP_IDX_PERH: rd_data = period_high_half;
         `TP_IDX_CTLL: rd_data = low_half_control;
         `TP_IDX_CTLH: rd_data = high_half_control;
         `TP_IDX_STAT: begin
            rd_data[`TP_FLAG_L] = low_match_flag;
            rd_data[`TP_FLAG_H] = period_match_flag;
            rd_data[`TP_IE_L] = low_irq_enable;
            rd_data[`TP_IE_H] = period_match_irq_enable;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // One access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~rd_hit;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_data};
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_low_wr;
      psel && !penable && pwrite && idx == `TP_IDX_LCNT ##1 acc;
   endsequence

   sequence s_low_rd;
      setup && !pwrite && idx == `TP_IDX_LCNT;
   endsequence

   AST_HOLD_LOAD: assert property ( // RULE8
      s_low_wr ##0 combined |=> high_half_count == $past(high_half_holding))
      else $error("high count not loaded from holding");

   AST_LOW_READ: assert property ( // RULE7
      s_low_rd |=> high_half_holding == $past(high_half_count))
      else $error("holding not captured on low read");

   AST_WRAP32: assert property ( // RULE6
      combined && tick[0] && cat_cnt == cat_per && !cnt_wr |=> cat_cnt == 32'h0000_0000)
      else $error("combined count did not wrap");

   AST_STEP32: assert property ( // RULE1
      combined && tick[0] && cat_cnt != cat_per && !cnt_wr
      |=> cat_cnt == $past(cat_cnt) + 32'h0000_0001)
      else $error("combined count did not carry");

   AST_TRIGGER: assert property ( // RULE14
      combined && tick[0] && cat_cnt == cat_per && !cnt_wr |=> adc_trigger)
      else $error("no trigger on combined match");

   AST_PS_CLEAR: assert property ( // RULE17
      ps_clr[0] |=> ps[0] == 8'h00)
      else $error("prescaler not cleared");

   AST_OFF_FROZEN: assert property ( // RULE18
      !t_on[0] |=> $stable(ps[0]))
      else $error("prescaler moved while off");

   AST_IDLE_STOP: assert property ( // RULE10
      !t_run[0] && !wr_lcnt |=> $stable(low_half_count))
      else $error("low count moved while stopped");

   AST_CTL_KEEPS: assert property ( // RULE19
      (wr_ctll || wr_ctlh) && !tick[0] && !tick[1] |=> $stable(cat_cnt))
      else $error("control write changed a count");

   AST_FLAG_STICKY: assert property ( // RULE20
      period_match_flag && !clr_h |=> period_match_flag)
      else $error("match flag dropped by hardware");

   AST_GATE_END: assert property ( // RULE13
      combined && gate_fall[0] && !cnt_wr && !tick[0]
      |=> period_match_flag && $stable(cat_cnt))
      else $error("gate fall mishandled");

endmodule // timer_pair

// ===== test/ext_pin_model.sv
`timescale 1ns/1ps
// ************************************
// External clock or gate source
// ************************************
module ext_pin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic idle_level,
   input wire logic [7:0] half_period,
   output logic pin
);
   logic [7:0] cnt;
   // Held still between bursts so no stray edge reaches the synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         pin <= 1'b0;
      end else if (!run) begin
         cnt <= 8'h00;
         pin <= idle_level;
      end else if (cnt == half_period - 8'h01) begin
         cnt <= 8'h00;
         pin <= ~pin;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule // ext_pin_model

// ===== test/timer_pair_tb.sv
`timescale 1ns/1ps
`include "timer_pair_regs.svh"
// ************************************
// Timer pair testbench
// ************************************
module timer_pair_tb;
   localparam logic [11:0] A_LCNT = {`TP_IDX_LCNT, 2'b00};
   localparam logic [11:0] A_HOLD = {`TP_IDX_HOLD, 2'b00};
   localparam logic [11:0] A_HCNT = {`TP_IDX_HCNT, 2'b00};
   localparam logic [11:0] A_PERL = {`TP_IDX_PERL, 2'b00};
   localparam logic [11:0] A_PERH = {`TP_IDX_PERH, 2'b00};
   localparam logic [11:0] A_CTLL = {`TP_IDX_CTLL, 2'b00};
   localparam logic [11:0] A_CTLH = {`TP_IDX_CTLH, 2'b00};
   localparam logic [11:0] A_STAT = {`TP_IDX_STAT, 2'b00};
   logic pclk, presetn, psel, penable, pwrite, cpu_idle, cpu_sleep, run, lvl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, low_irq, high_irq, adc_trigger, pin;
   int num_errors = 0;
   int n_checks = 0;

   timer_pair timer_pair_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_clock_gate_pin(pin), .high_half_ext_pin(pin), .cpu_idle(cpu_idle),
      .cpu_sleep(cpu_sleep), .low_irq_req(low_irq), .high_irq_req(high_irq),
      .adc_trigger(adc_trigger));
   ext_pin_model ext_pin_model_inst (.pclk(pclk), .presetn(presetn), .run(run),
      .idle_level(lvl), .half_period(8'h04), .pin(pin));

   always #2.5 pclk = ~pclk;

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi,
                      input string what);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         num_errors++;
         $display("BAD %0t %s got %h range %h..%h", $time, what, got, lo, hi);
      end
   endtask

   // Holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("BAD %0t no pready", $time);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 16'h0000, q, e);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      rd(a, q);
      chk(q, exp, "read");
   endtask

   task automatic t_reset;
      logic [11:0] ad [7];
      logic [31:0] ex [7];
      logic [31:0] q;
      logic e;
      ad = '{A_LCNT, A_HCNT, A_PERL, A_PERH, A_CTLL, A_CTLH, A_STAT};
      ex = '{32'h0000_0000, 32'h0000_0000, 32'h0000_ffff, 32'h0000_ffff,
             32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
      for (int i = 0; i < 7; i++) begin
         rdc(ad[i], ex[i]);
      end
      apb(1'b0, 12'h000, 16'h0000, q, e);
      chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped err");
      chk(q, 32'h0000_0000, "unmapped data");
      wr(A_CTLL, 16'hffff);
      rdc(A_CTLL, 32'h0000_a07a);
      wr(A_CTLL, 16'h0000);
   endtask

   task automatic t_prescale;
      int sh [4] = '{0, 3, 6, 8};
      logic [31:0] q, r, x;
      for (int i = 0; i < 4; i++) begin
         wr(A_LCNT, 16'h0000);
         wr(A_CTLL, 16'h8000 | (16'(i) << 4));
         repeat (2048) @(posedge pclk);
         wr(A_CTLL, 16'(i) << 4);
         x = 32'h0000_0800 >> sh[i];
         rd(A_LCNT, q);
         rng(q, x - 3, x + 3, "prescale");
         repeat (10) @(posedge pclk);
         rd(A_LCNT, r);
         chk(r, q, "count kept");
      end
   endtask

   task automatic t_clear;
      wr(A_CTLL, 16'h8030);
      wr(A_LCNT, 16'h0000);
      repeat (200) @(posedge pclk);
      wr(A_LCNT, 16'h0000);
      repeat (200) @(posedge pclk);
      rdc(A_LCNT, 32'h0000_0000);
      wr(A_CTLL, 16'h0000);
   endtask

   task automatic t_idle;
      logic [31:0] a, b, c;
      wr(A_LCNT, 16'h0000);
      wr(A_CTLL, 16'ha000);
      cpu_idle <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(A_LCNT, a);
      repeat (50) @(posedge pclk);
      rd(A_LCNT, b);
      chk(b, a, "idle stop");
      cpu_idle <= 1'b0;
      repeat (50) @(posedge pclk);
      rd(A_LCNT, c);
      rng(c, b + 40, b + 70, "idle resume");
      wr(A_CTLL, 16'h8000);
      cpu_idle <= 1'b1;
      rd(A_LCNT, a);
      repeat (50) @(posedge pclk);
      rd(A_LCNT, b);
      rng(b, a + 50, a + 60, "idle run");
      cpu_idle <= 1'b0;
      cpu_sleep <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(A_LCNT, a);
      repeat (50) @(posedge pclk);
      rdc(A_LCNT, a);
      cpu_sleep <= 1'b0;
      wr(A_CTLL, 16'h0000);
   endtask

   task automatic t_gate;
      logic [31:0] q;
      wr(A_LCNT, 16'h0000);
      wr(A_CTLL, 16'h8040);
      repeat (20) @(posedge pclk);
      rdc(A_LCNT, 32'h0000_0000);
      lvl <= 1'b1;
      repeat (40) @(posedge pclk);
      lvl <= 1'b0;
      repeat (10) @(posedge pclk);
      rd(A_LCNT, q);
      rng(q, 38, 42, "gated");
      rdc(A_STAT, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      rdc(A_LCNT, q);
      wr(A_STAT, 16'h0100);
      repeat (3) @(posedge pclk);
      chk({31'h0000_0000, low_irq}, 32'h0000_0001, "low irq on");
      wr(A_CTLL, 16'h0000);
      wr(A_STAT, 16'h0001);
      rdc(A_STAT, 32'h0000_0000);
      chk({31'h0000_0000, low_irq}, 32'h0000_0000, "low irq off");
      // Cascaded gate at 1:8; high timer set to gate at 1:1 must be ignored
      wr(A_CTLH, 16'h8040);
      wr(A_LCNT, 16'h0000);
      wr(A_CTLL, 16'h8058);
      lvl <= 1'b1;
      repeat (20) @(posedge pclk);
      lvl <= 1'b0;
      repeat (10) @(posedge pclk);
      rdc(A_LCNT, 32'h0000_0002);
      rdc(A_HCNT, 32'h0000_0000);
      rdc(A_STAT, 32'h0000_0002);
      wr(A_CTLL, 16'h0000);
      wr(A_CTLH, 16'h0000);
      wr(A_STAT, 16'h0002);
      rdc(A_STAT, 32'h0000_0000);
   endtask

   task automatic t_ext;
      logic [31:0] q;
      run <= 1'b1;
      wr(A_LCNT, 16'h0000);
      wr(A_HCNT, 16'h0000);
      wr(A_CTLH, 16'h8002);
      wr(A_CTLL, 16'h8002);
      repeat (160) @(posedge pclk);
      wr(A_CTLL, 16'h0000);
      wr(A_CTLH, 16'h0000);
      run <= 1'b0;
      rd(A_LCNT, q);
      rng(q, 16, 23, "low ext");
      rd(A_HCNT, q);
      rng(q, 17, 24, "high ext");
   endtask

   task automatic t_cascade;
      logic [31:0] q, h;
      int n;
      wr(A_CTLL, 16'h0008);
      wr(A_HOLD, 16'h0012);
      wr(A_LCNT, 16'hfff0);
      rdc(A_HCNT, 32'h0000_0012);
      wr(A_PERL, 16'h0005);
      wr(A_PERH, 16'h0013);
      wr(A_CTLH, 16'h8030);
      wr(A_CTLL, 16'h8008);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (adc_trigger !== 1'b1 && n < 100);
      rng(n, 20, 27, "match time");
      wr(A_CTLL, 16'h0008);
      rd(A_LCNT, q);
      rng(q, 1, 12, "low after wrap");
      rd(A_HOLD, h);
      chk(h, 32'h0000_0000, "held high");
      rdc(A_STAT, 32'h0000_0002);
      wr(A_STAT, 16'h0200);
      repeat (3) @(posedge pclk);
      chk({31'h0000_0000, high_irq}, 32'h0000_0001, "irq on");
      wr(A_STAT, 16'h0202);
      repeat (3) @(posedge pclk);
      chk({31'h0000_0000, high_irq}, 32'h0000_0000, "irq off");
      wr(A_STAT, 16'h0000);
      wr(A_CTLH, 16'h0000);
      wr(A_CTLL, 16'h0000);
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      wrap_up();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, cpu_idle, cpu_sleep, run, lvl} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_prescale();
      t_clear();
      t_idle();
      t_gate();
      t_ext();
      t_cascade();
      wrap_up();
   end
endmodule // timer_pair_tb
